// [logic/iepr_map.vh]
`ifndef IEPR_MAP_VH
`define IEPR_MAP_VH
// special function register addresses
`define IEPR_ADDR_EN_MAIN   8'hA8
`define IEPR_ADDR_PR_MAIN   8'hB8
`define IEPR_ADDR_PEND      8'hC0
`define IEPR_ADDR_SENSE     8'hE1
`define IEPR_ADDR_PIN_EN    8'hE8
`define IEPR_ADDR_POLARITY  8'hE9
`define IEPR_ADDR_EN_AUX    8'hF1
`define IEPR_ADDR_PIN_PR    8'hF8
`define IEPR_ADDR_PR_AUX    8'hF9
// writable bit masks, reserved positions zero
`define IEPR_EN_MAIN_MASK   8'hEF
`define IEPR_PR_MAIN_MASK   8'h6F
`define IEPR_AUX_MASK       8'h83
// field positions
`define IEPR_GLOBAL_BIT     7
// source bit positions inside the main enable and priority registers
`define IEPR_BIT_TIMER2     6
`define IEPR_BIT_I2C        5
`define IEPR_BIT_TIMER1     3
`define IEPR_BIT_EXT1       2
`define IEPR_BIT_TIMER0     1
`define IEPR_BIT_EXT0       0
// source bit positions inside the aux enable and priority registers
`define IEPR_BIT_WDOG       7
`define IEPR_BIT_MODEM_TX   1
`define IEPR_BIT_MODEM_RX   0
// source index on the request and priority outputs
`define IEPR_SRC_EXT0       0
`define IEPR_SRC_TIMER0     1
`define IEPR_SRC_EXT1       2
`define IEPR_SRC_TIMER1     3
`define IEPR_SRC_I2C        4
`define IEPR_SRC_TIMER2     5
`define IEPR_SRC_PIN_LO     6
`define IEPR_SRC_PIN_HI     13
`define IEPR_SRC_MODEM_TX   14
`define IEPR_SRC_MODEM_RX   15
`define IEPR_SRC_WDOG       16
`define IEPR_ZERO17         17'h00000
`define IEPR_RESET_VAL      8'h00
`define IEPR_ZERO8          8'h00
`endif

// [logic/iepr_regs.v]
// How it works
// - global allow bit 7 gates every request; priority outputs and pending flags are not gated
// - enable bit one means source enabled
// - main enable: timers, i2c, ext0/1 mapping
// - pin enable bits 7..0 are pins 9..2
// - aux enable: watchdog, modem tx, rx
// - priority bit one means high priority
// - main priority mirrors main enable layout
// - pin priority bits 7..0 are pins 9..2
// - aux priority: watchdog, modem tx, rx
// - pending flags bits 7..0 are pins 9..2
// - level sense: polarity picks high or low
// - edge sense: polarity picks rising or falling
// - sense bit one edge, zero level
// - valid enabled pin event sets pending flag
`timescale 1ns/1ps
`include "iepr_map.vh"
module iepr_regs #(
   parameter NPIN = 8
) (
   // clock and reset
   input  wire              core_clk,
   input  wire              rst_b,
   // special function register port
   input  wire [7:0]        sfr_addr,
   input  wire              sfr_wr,
   input  wire              sfr_rd,
   input  wire [7:0]        sfr_wdata,
   output reg  [7:0]        sfr_rdata,
   output wire              sfr_hit,
   // pending conditions of the fixed sources, same clock
   input  wire              ext0_req,
   input  wire              timer0_req,
   input  wire              ext1_req,
   input  wire              timer1_req,
   input  wire              i2c_req,
   input  wire              timer2_req,
   input  wire              modem_tx_req,
   input  wire              modem_rx_req,
   input  wire              watchdog_req,
   // port pin interrupt inputs, asynchronous
   input  wire [NPIN-1:0]   pin_irq_in,
   // gated requests and their priority toward the decoder
   output reg  [16:0]       irq_request,
   output reg  [16:0]       irq_high_prio
);

////////////////////////////////////////////////////////////////////////
reg  [7:0]      en_main_q;
reg  [7:0]      pr_main_q;
reg  [NPIN-1:0] pend_q;
reg  [NPIN-1:0] pend_d;
reg  [NPIN-1:0] sense_q;
reg  [NPIN-1:0] pin_en_q;
reg  [NPIN-1:0] pol_q;
reg  [7:0]      en_aux_q;
reg  [NPIN-1:0] pin_pr_q;
reg  [7:0]      pr_aux_q;
reg  [NPIN-1:0] sync1_q;
reg  [NPIN-1:0] sync2_q;
reg  [NPIN-1:0] prev_q;
reg  [16:0]     pend_all;
reg  [16:0]     allow_all;
reg  [16:0]     prio_all;
wire [NPIN-1:0] pin_event;
wire            global_irq_allow;
wire [NPIN-1:0] pend_set;
reg  [16:0]     req_all;
wire            wr_en_main;
wire            wr_pr_main;
wire            wr_pend;
wire            wr_sense;
wire            wr_pin_en;
wire            wr_pol;
wire            wr_en_aux;
wire            wr_pin_pr;
wire            wr_pr_aux;

function sel;
   input [7:0] a;
   input [7:0] b;
   begin
      sel = (a == b);
   end
endfunction

// address decode shared by the hit flag
function mapped;
   input [7:0] a;
   begin
      case (a)
         `IEPR_ADDR_EN_MAIN,
         `IEPR_ADDR_PR_MAIN,
         `IEPR_ADDR_PEND,
         `IEPR_ADDR_SENSE,
         `IEPR_ADDR_PIN_EN,
         `IEPR_ADDR_POLARITY,
         `IEPR_ADDR_EN_AUX,
         `IEPR_ADDR_PIN_PR,
         `IEPR_ADDR_PR_AUX:   mapped = 1'b1;
         default:             mapped = 1'b0;
      endcase
   end
endfunction

// per-pin detector
function detect;
   input sense;
   input pol;
   input now;
   input prev;
   begin
      if (sense) begin
         detect = pol ? (now & ~prev) : (~now & prev);
      end else begin
         detect = pol ? now : ~now;
      end
   end
endfunction

////////////////////////////////////////////////////////////////////////
// pins pass two flops before any detector looks at them
always @(posedge core_clk) begin
   if (!rst_b) begin
      sync1_q <= {NPIN{1'b0}};
      sync2_q <= {NPIN{1'b0}};
      prev_q  <= {NPIN{1'b0}};
   end else begin
      sync1_q <= pin_irq_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
   end
end

genvar gi;
generate
   for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_det
      assign pin_event[gi] = detect(sense_q[gi], pol_q[gi], sync2_q[gi], prev_q[gi]);
   end
endgenerate

////////////////////////////////////////////////////////////////////////
// one write strobe per register
assign wr_en_main = sfr_wr & sel(sfr_addr, `IEPR_ADDR_EN_MAIN);
assign wr_pr_main = sfr_wr & sel(sfr_addr, `IEPR_ADDR_PR_MAIN);
assign wr_pend    = sfr_wr & sel(sfr_addr, `IEPR_ADDR_PEND);
assign wr_sense   = sfr_wr & sel(sfr_addr, `IEPR_ADDR_SENSE);
assign wr_pin_en  = sfr_wr & sel(sfr_addr, `IEPR_ADDR_PIN_EN);
assign wr_pol     = sfr_wr & sel(sfr_addr, `IEPR_ADDR_POLARITY);
assign wr_en_aux  = sfr_wr & sel(sfr_addr, `IEPR_ADDR_EN_AUX);
assign wr_pin_pr  = sfr_wr & sel(sfr_addr, `IEPR_ADDR_PIN_PR);
assign wr_pr_aux  = sfr_wr & sel(sfr_addr, `IEPR_ADDR_PR_AUX);

////////////////////////////////////////////////////////////////////////
// events only count on enabled pins
assign pend_set = pin_event & pin_en_q;

// pending flags: a set in the same cycle as a software clear wins
always @* begin
   pend_d = pend_q;
   if (wr_pend) begin
      pend_d = sfr_wdata[NPIN-1:0];
   end
   pend_d = pend_d | pend_set;
end

////////////////////////////////////////////////////////////////////////
always @(posedge core_clk) begin
   if (!rst_b) begin
      en_main_q <= `IEPR_RESET_VAL;
      pr_main_q <= `IEPR_RESET_VAL;
      pend_q    <= {NPIN{1'b0}};
      sense_q   <= {NPIN{1'b0}};
      pin_en_q  <= {NPIN{1'b0}};
      pol_q     <= {NPIN{1'b0}};
      en_aux_q  <= `IEPR_RESET_VAL;
      pin_pr_q  <= {NPIN{1'b0}};
      pr_aux_q  <= `IEPR_RESET_VAL;
   end else begin
      pend_q <= pend_d;
      if (wr_en_main) begin
         en_main_q <= sfr_wdata & `IEPR_EN_MAIN_MASK;
      end
      if (wr_pr_main) begin
         pr_main_q <= sfr_wdata & `IEPR_PR_MAIN_MASK;
      end
      if (wr_en_aux) begin
         en_aux_q <= sfr_wdata & `IEPR_AUX_MASK;
      end
      if (wr_pr_aux) begin
         pr_aux_q <= sfr_wdata & `IEPR_AUX_MASK;
      end
      if (wr_sense) begin
         sense_q <= sfr_wdata[NPIN-1:0];
      end
      if (wr_pin_en) begin
         pin_en_q <= sfr_wdata[NPIN-1:0];
      end
      if (wr_pol) begin
         pol_q <= sfr_wdata[NPIN-1:0];
      end
      if (wr_pin_pr) begin
         pin_pr_q <= sfr_wdata[NPIN-1:0];
      end
   end
end

////////////////////////////////////////////////////////////////////////
assign sfr_hit = mapped(sfr_addr);

// read data registered, one cycle after the read strobe
always @(posedge core_clk) begin
   if (!rst_b) begin
      sfr_rdata <= `IEPR_ZERO8;
   end else if (sfr_rd) begin
      case (sfr_addr)
         `IEPR_ADDR_EN_MAIN:  sfr_rdata <= en_main_q;
         `IEPR_ADDR_PR_MAIN:  sfr_rdata <= pr_main_q;
         `IEPR_ADDR_PEND:     sfr_rdata <= pend_q;
         `IEPR_ADDR_SENSE:    sfr_rdata <= sense_q;
         `IEPR_ADDR_PIN_EN:   sfr_rdata <= pin_en_q;
         `IEPR_ADDR_POLARITY: sfr_rdata <= pol_q;
         `IEPR_ADDR_EN_AUX:   sfr_rdata <= en_aux_q;
         `IEPR_ADDR_PIN_PR:   sfr_rdata <= pin_pr_q;
         `IEPR_ADDR_PR_AUX:   sfr_rdata <= pr_aux_q;
         default:             sfr_rdata <= `IEPR_ZERO8;
      endcase
   end
end

////////////////////////////////////////////////////////////////////////
// source order: ext0, t0, ext1, t1, i2c, t2, pins 2..9, mtx, mrx, wd
assign global_irq_allow = en_main_q[`IEPR_GLOBAL_BIT];

always @* begin
   pend_all[`IEPR_SRC_EXT0]                    = ext0_req;
   pend_all[`IEPR_SRC_TIMER0]                  = timer0_req;
   pend_all[`IEPR_SRC_EXT1]                    = ext1_req;
   pend_all[`IEPR_SRC_TIMER1]                  = timer1_req;
   pend_all[`IEPR_SRC_I2C]                     = i2c_req;
   pend_all[`IEPR_SRC_TIMER2]                  = timer2_req;
   pend_all[`IEPR_SRC_PIN_HI:`IEPR_SRC_PIN_LO] = pend_q;
   pend_all[`IEPR_SRC_MODEM_TX]                = modem_tx_req;
   pend_all[`IEPR_SRC_MODEM_RX]                = modem_rx_req;
   pend_all[`IEPR_SRC_WDOG]                    = watchdog_req;
   allow_all[`IEPR_SRC_EXT0]                    = en_main_q[`IEPR_BIT_EXT0];
   allow_all[`IEPR_SRC_TIMER0]                  = en_main_q[`IEPR_BIT_TIMER0];
   allow_all[`IEPR_SRC_EXT1]                    = en_main_q[`IEPR_BIT_EXT1];
   allow_all[`IEPR_SRC_TIMER1]                  = en_main_q[`IEPR_BIT_TIMER1];
   allow_all[`IEPR_SRC_I2C]                     = en_main_q[`IEPR_BIT_I2C];
   allow_all[`IEPR_SRC_TIMER2]                  = en_main_q[`IEPR_BIT_TIMER2];
   allow_all[`IEPR_SRC_PIN_HI:`IEPR_SRC_PIN_LO] = pin_en_q;
   allow_all[`IEPR_SRC_MODEM_TX]                = en_aux_q[`IEPR_BIT_MODEM_TX];
   allow_all[`IEPR_SRC_MODEM_RX]                = en_aux_q[`IEPR_BIT_MODEM_RX];
   allow_all[`IEPR_SRC_WDOG]                    = en_aux_q[`IEPR_BIT_WDOG];
   prio_all[`IEPR_SRC_EXT0]                    = pr_main_q[`IEPR_BIT_EXT0];
   prio_all[`IEPR_SRC_TIMER0]                  = pr_main_q[`IEPR_BIT_TIMER0];
   prio_all[`IEPR_SRC_EXT1]                    = pr_main_q[`IEPR_BIT_EXT1];
   prio_all[`IEPR_SRC_TIMER1]                  = pr_main_q[`IEPR_BIT_TIMER1];
   prio_all[`IEPR_SRC_I2C]                     = pr_main_q[`IEPR_BIT_I2C];
   prio_all[`IEPR_SRC_TIMER2]                  = pr_main_q[`IEPR_BIT_TIMER2];
   prio_all[`IEPR_SRC_PIN_HI:`IEPR_SRC_PIN_LO] = pin_pr_q;
   prio_all[`IEPR_SRC_MODEM_TX]                = pr_aux_q[`IEPR_BIT_MODEM_TX];
   prio_all[`IEPR_SRC_MODEM_RX]                = pr_aux_q[`IEPR_BIT_MODEM_RX];
   prio_all[`IEPR_SRC_WDOG]                    = pr_aux_q[`IEPR_BIT_WDOG];
   req_all = pend_all & allow_all & {17{global_irq_allow}};
end

////////////////////////////////////////////////////////////////////////
// request outputs registered so the decoder sees a clean value
always @(posedge core_clk) begin
   if (!rst_b) begin
      irq_request <= `IEPR_ZERO17;
   end else begin
      irq_request <= req_all;
   end
end

always @(posedge core_clk) begin
   if (!rst_b) begin
      irq_high_prio <= `IEPR_ZERO17;
   end else begin
      irq_high_prio <= prio_all;
   end
end

endmodule

// [bench/iepr_regs_chk.sv]
`timescale 1ns/1ps
module iepr_chk (
   // clock, reset, register port
   input logic        core_clk,
   input logic        rst_b,
   input logic [7:0]  sfr_addr,
   input logic        sfr_wr,
   input logic        sfr_rd,
   input logic [7:0]  sfr_wdata,
   input logic [7:0]  sfr_rdata,
   input logic        sfr_hit,
   // sources and requests
   input logic        timer0_req,
   input logic        watchdog_req,
   input logic [16:0] irq_request,
   input logic [16:0] irq_high_prio
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   logic       glob_q;
   logic [7:0] resv;
   // unmapped addresses count as all reserved
   assign resv = (sfr_addr == 8'hA8) ? 8'h10 : (sfr_addr == 8'hB8) ? 8'h90 :
      (sfr_addr == 8'hF1 || sfr_addr == 8'hF9) ? 8'h7C :
      (sfr_addr inside {8'hC0, 8'hE1, 8'hE8, 8'hE9, 8'hF8}) ? 8'h00 : 8'hFF;
   always_ff @(posedge core_clk)
      glob_q <= !rst_b ? 1'b0 : (sfr_wr && sfr_addr == 8'hA8) ? sfr_wdata[7] : glob_q;
   sequence s_wr_main; sfr_wr && sfr_addr == 8'hA8; endsequence
   sequence s_rd_main; sfr_rd && sfr_addr == 8'hA8; endsequence
   a_resv_zero: assert property (sfr_rd |=> (sfr_rdata & $past(resv)) == 8'h00)
      else $error("reserved bits read");
   a_hit_decode: assert property (sfr_hit == (resv != 8'hFF))
      else $error("bad hit");
   a_main_back: assert property (s_wr_main ##2 s_rd_main |=> sfr_rdata == ($past(sfr_wdata, 3) & 8'hEF))
      else $error("bad readback");
   a_global_off: assert property (!glob_q |=> irq_request == 17'h0)
      else $error("request while off");
   a_timer0_gate: assert property (irq_request[1] |-> $past(timer0_req))
      else $error("timer0 ungated");
   a_wdog_gate: assert property (irq_request[16] |-> $past(watchdog_req))
      else $error("watchdog ungated");
   a_prio_quiet: assert property (!$stable(irq_high_prio) |-> $past(sfr_wr, 2))
      else $error("priority moved");
   a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
      else $error("read data moved");
endmodule

// [bench/iepr_cpu.sv]
`timescale 1ns/1ps
module iepr_cpu (
   // clock
   input  logic       core_clk,
   // register port
   output logic [7:0] sfr_addr = 8'h00,
   output logic       sfr_wr = 1'b0,
   output logic       sfr_rd = 1'b0,
   output logic [7:0] sfr_wdata = 8'h00
);
   // data inverted on release so a stale byte never passes for a write
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge core_clk);
      sfr_wr <= 1'b0;
      sfr_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge core_clk);
      sfr_rd <= 1'b0;
   endtask
endmodule

// [bench/iepr_regs_tb.sv]
`timescale 1ns/1ps
module iepr_regs_tb;
   logic        core_clk;
   logic        rst_b = 1'b0;
   logic        hold = 1'b0;
   logic        rd_seen = 1'b0;
   logic [8:0]  req = 9'h000;
   logic [7:0]  pin = 8'hFF;
   logic [7:0]  e;
   logic [7:0]  exp_q[$];
   logic [7:0]  adr[9] = '{8'hA8, 8'hB8, 8'hC0, 8'hE1, 8'hE8, 8'hE9, 8'hF1, 8'hF8, 8'hF9};
   logic [7:0]  msk[9] = '{8'hEF, 8'h6F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h83, 8'hFF, 8'h83};
   wire  [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
   wire         sfr_wr, sfr_rd, sfr_hit;
   wire  [16:0] irq_request, irq_high_prio;
   int          errors = 0;
   int          checks_done = 0;
   int          k;
   integer      seed = 32'h08565168;
   iepr_cpu u_iepr_cpu (.core_clk(core_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata));
   iepr_regs u_iepr_regs (.core_clk(core_clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .ext0_req(req[0]),
      .timer0_req(req[1]), .ext1_req(req[2]), .timer1_req(req[3]), .i2c_req(req[4]), .timer2_req(req[5]),
      .modem_tx_req(req[6]), .modem_rx_req(req[7]), .watchdog_req(req[8]), .pin_irq_in(pin),
      .irq_request(irq_request), .irq_high_prio(irq_high_prio));
   task automatic chk(input logic [16:0] seen, input logic [16:0] want);
      checks_done++;
      if (seen !== want) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic finish_test;
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic rdx(input logic [7:0] a, input logic [7:0] want);
      exp_q.push_back(want);
      u_iepr_cpu.rd(a);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #100000;
      errors++;
      finish_test;
   end
   always @(posedge core_clk) begin
      req <= hold ? 9'h1FF : 9'($random(seed));
      if (rd_seen) chk(17'(sfr_rdata), 17'(exp_q.pop_front()));
      rd_seen <= sfr_rd;
   end
   initial begin
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      for (k = 0; k < 9; k++) begin
         rdx(adr[k], 8'h00);
         e = 8'($random(seed));
         u_iepr_cpu.wr(adr[k], e);
         rdx(adr[k], e & msk[k]);
      end
      u_iepr_cpu.wr(8'h00, 8'hFF);
      rdx(8'h00, 8'h00);
      hold <= 1'b1;
      u_iepr_cpu.wr(8'hE8, 8'h00);
      u_iepr_cpu.wr(8'hC0, 8'h00);
      u_iepr_cpu.wr(8'hF1, 8'h83);
      for (k = 0; k < 2; k++) begin
         u_iepr_cpu.wr(8'hA8, k ? 8'hEF : 8'h6F);
         repeat (3) @(posedge core_clk);
         chk(irq_request, k ? 17'h1C03F : 17'h00000);
      end
      u_iepr_cpu.wr(8'hB8, 8'hFF);
      u_iepr_cpu.wr(8'hF8, 8'hA5);
      u_iepr_cpu.wr(8'hF9, 8'h81);
      repeat (3) @(posedge core_clk);
      chk(irq_high_prio, 17'h1A97F);
      // edge sense, falling then rising; pin 9 left disabled
      u_iepr_cpu.wr(8'hE1, 8'hFF);
      for (k = 0; k < 2; k++) begin
         pin <= k ? 8'h00 : 8'hFF;
         u_iepr_cpu.wr(8'hE9, k ? 8'hFF : 8'h00);
         u_iepr_cpu.wr(8'hE8, 8'h7F);
         u_iepr_cpu.wr(8'hC0, 8'h00);
         pin <= ~pin;
         repeat (3) @(posedge core_clk);
         rdx(8'hC0, 8'h7F);
         chk(17'(irq_request[13:6]), 17'h0007F);
         u_iepr_cpu.wr(8'hC0, 8'h00);
         rdx(8'hC0, 8'h00);
      end
      u_iepr_cpu.wr(8'hE1, 8'h00);
      u_iepr_cpu.wr(8'hC0, 8'h00);
      rdx(8'hC0, 8'h7F);
      u_iepr_cpu.wr(8'hE9, 8'h00);
      u_iepr_cpu.wr(8'hC0, 8'h00);
      rdx(8'hC0, 8'h00);
      repeat (2) @(posedge core_clk);
      finish_test;
   end
endmodule
bind iepr_regs iepr_chk u_chk (.core_clk(core_clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
   .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .timer0_req(timer0_req),
   .watchdog_req(watchdog_req), .irq_request(irq_request), .irq_high_prio(irq_high_prio));
